// [flash_cmd_decoder.sv]
// Purpose: command engine for reads, burst wrap, page program, status write
// Assumes: sclk half period spans at least four sys_clk cycles
// Notes: mem_rdata must follow rd_addr within one sys_clk cycle
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CNT,
  parameter int STAT_CYCLES = STAT_CNT
) (
  input  wire logic        sys_clk,          // 20 MHz clock
  input  wire logic        rst,              // Synchronous reset
  input  wire logic        ce,               // Clock enable
  input  wire spi_pins_t   pins,             // Raw SPI pins
  output logic      [3:0]  lane_out,         // Lane drive values
  output logic      [3:0]  lane_oe,          // Lane output enables
  output logic      [23:0] rd_addr,          // Array read address
  input  wire logic [7:0]  mem_rdata,        // Array read data
  output logic             wr_en,            // Array byte write strobe
  output logic      [23:0] wr_addr,          // Array write address
  output logic      [7:0]  wr_data,          // Array write data
  output logic      [15:0] prot_page,        // Page under program
  input  wire logic        page_locked,      // Page is protected
  output logic             busy,             // Self-timed cycle running
  output logic             write_latch_flag, // Write latch
  output logic             quad_lane_enable, // Quad enable bit
  output logic      [7:0]  status_one,       // First status register
  output logic      [7:0]  status_two,       // Second status register
  output wrap_cfg_t        wrap_cfg          // Stored wrap setting
);

  function automatic logic [2:0] addr_w(input logic [7:0] o);
    case (o)
      OP_DIO:         addr_w = 3'd2;
      OP_QIO, OP_WRAP: addr_w = 3'd4;
      default:        addr_w = 3'd1;
    endcase
  endfunction : addr_w

  function automatic logic [2:0] data_w(input logic [7:0] o);
    case (o)
      OP_DOR, OP_DIO:          data_w = 3'd2;
      OP_QOR, OP_QIO, OP_WRAP: data_w = 3'd4;
      default:                 data_w = 3'd1;
    endcase
  endfunction : data_w

  function automatic logic [3:0] dummy_clks(input logic [7:0] o);
    case (o)
      OP_FRD, OP_DOR, OP_QOR: dummy_clks = 4'(FAST_DUMMY);
      OP_DIO:                 dummy_clks = 4'(DIO_MODE);
      OP_QIO:                 dummy_clks = 4'(QIO_DUMMY);
      default:                dummy_clks = 4'd0;
    endcase
  endfunction : dummy_clks

  // Lane three lands in the most significant position
  function automatic logic [23:0] shift_in(input logic [23:0] v,
                                           input logic [3:0]  l,
                                           input logic [2:0]  w);
    case (w)
      3'd2:    shift_in = {v[21:0], l[1:0]};
      3'd4:    shift_in = {v[19:0], l};
      default: shift_in = {v[22:0], l[0]};
    endcase
  endfunction : shift_in

  spi_pins_t  s1, s2, s3, pin, stab;
  phase_t     phase, next_phase;
  logic [7:0] op, next_op, sh, next_sh, st1, next_st1, st2, next_st2;
  logic [5:0] cnt, next_cnt;
  logic [2:0] bcnt, next_bcnt;
  logic [1:0] got, next_got;
  logic [23:0] addr, next_addr, next_rd_addr, next_wr_addr, nxt_a;
  logic [3:0] next_lane_out, next_lane_oe;
  logic       next_wel, next_busy, prog, next_prog, next_wr_en;
  logic [5:0] sr1h, next_sr1h;
  logic [7:0] sr2, next_sr2, next_wr_data, byte_v, pg_idx, next_pg_idx;
  logic [15:0] next_prot_page;
  wrap_cfg_t  next_wrap;
  logic [19:0] bcyc, next_bcyc;
  logic       rise, fall, cs_up, buf_we, clr_mask, in_op;
  logic [2:0] w, last;
  logic [23:0] sh_in;
  logic [7:0] pg_buf  [PAGE_BYTES];
  logic       pg_mask [PAGE_BYTES];

  // Section-bounded increment for wrapped quad I/O reads
  function automatic logic [23:0] next_rd(input logic [23:0] a,
                                          input logic [7:0]  o,
                                          input wrap_cfg_t   c);
    logic [23:0] m;
    m = 24'(8 << c.len) - 24'd1;
    if (o == OP_QIO && !c.dis)
      next_rd = (a & ~m) | ((a + 24'd1) & m);
    else
      next_rd = a + 24'd1;
  endfunction : next_rd

  // Pin filter: a bit moves once stages two and three agree
  always_comb begin
    stab = (s2 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1  <= PINS_IDLE;
      s2  <= PINS_IDLE;
      s3  <= PINS_IDLE;
      pin <= PINS_IDLE;
    end else if (ce) begin
      s1  <= pins;
      s2  <= s1;
      s3  <= s2;
      pin <= stab;
    end
  end

  assign status_one       = {sr1h, write_latch_flag, busy};
  assign status_two       = sr2;
  assign quad_lane_enable = sr2[QUAD_EN_BIT];

  // Command engine; edges only count while chip select is low
  always_comb begin
    next_phase     = phase;
    next_op        = op;
    next_cnt       = cnt;
    next_bcnt      = bcnt;
    next_got       = got;
    next_addr      = addr;
    next_sh        = sh;
    next_st1       = st1;
    next_st2       = st2;
    next_rd_addr   = rd_addr;
    next_lane_out  = lane_out;
    next_lane_oe   = lane_oe;
    next_wel       = write_latch_flag;
    next_sr1h      = sr1h;
    next_sr2       = sr2;
    next_wrap      = wrap_cfg;
    next_pg_idx    = pg_idx;
    next_prot_page = prot_page;
    next_busy      = busy;
    next_prog      = prog;
    next_bcyc      = bcyc;
    next_wr_en     = 1'b0;
    next_wr_addr   = wr_addr;
    next_wr_data   = wr_data;
    buf_we         = 1'b0;
    clr_mask       = 1'b0;
    nxt_a          = shift_in(addr, stab.lane, addr_w(op));
    rise  = !stab.cs_n && !pin.sclk && stab.sclk;
    fall  = !stab.cs_n && pin.sclk && !stab.sclk;
    cs_up = !pin.cs_n && stab.cs_n;
    w     = data_w(op);
    last  = 3'(8 / w) - 3'd1;
    sh_in = shift_in({16'h0, sh}, stab.lane, w);
    in_op = (op == OP_PP) || (op == OP_WRSR) || (op == OP_WRAP);
    byte_v = (bcnt == 3'd0) ? ((op == OP_RDSR) ? status_one : mem_rdata) : sh;

    // Self-timed cycle: flush page bytes, then wait out the time
    if (busy) begin
      next_bcyc = bcyc + 20'd1;
      if (prog && bcyc < 20'(PAGE_BYTES) && pg_mask[bcyc[7:0]]) begin
        next_wr_en   = 1'b1;
        next_wr_addr = {prot_page, bcyc[7:0]};
        next_wr_data = pg_buf[bcyc[7:0]];
      end
      if (bcyc == 20'((prog ? PROG_CYCLES : STAT_CYCLES) - 1)) begin
        next_busy = 1'b0;
        next_wel  = 1'b0;
      end
    end

    if (stab.cs_n) begin
      next_phase   = ST_OPC;
      next_cnt     = 6'd0;
      next_bcnt    = 3'd0;
      next_lane_oe = 4'h0;
      // Commit only on a whole-byte boundary
      if (cs_up && phase == ST_XFER && bcnt == 3'd0) begin
        if (op == OP_PP && got != 2'd0 && write_latch_flag && !page_locked
            && !busy) begin
          next_busy = 1'b1;
          next_prog = 1'b1;
          next_bcyc = 20'd0;
        end
        if (op == OP_WRSR && got != 2'd0 && !busy) begin
          next_sr1h = st1[7:SR1_KEEP_LO];
          if (got == 2'd2)
            next_sr2 = st2;
          next_busy = 1'b1;
          next_prog = 1'b0;
          next_bcyc = 20'd0;
        end
      end
    end else if (rise) begin
      unique case (phase)
        ST_OPC: begin
          next_op  = {op[6:0], stab.lane[0]};
          next_cnt = cnt + 6'd1;
          if (cnt == 6'd7) begin
            next_cnt   = 6'd0;
            next_got   = 2'd0;
            next_phase = ST_DROP;
            if (!busy || next_op == OP_RDSR) begin
              case (next_op)
                OP_WREN: next_wel = 1'b1;
                OP_WRDI: next_wel = 1'b0;
                OP_RDSR: next_phase = ST_XFER;
                OP_WRSR: if (write_latch_flag) next_phase = ST_XFER;
                OP_PP:   if (write_latch_flag) next_phase = ST_ADDR;
                OP_QOR, OP_QIO:
                  if (quad_lane_enable) next_phase = ST_ADDR;
                OP_RD, OP_FRD, OP_DOR, OP_DIO, OP_WRAP:
                  next_phase = ST_ADDR;
                default: next_phase = ST_DROP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          next_addr = nxt_a;
          next_cnt  = cnt + 6'd1;
          if (cnt == 6'(ADDR_BITS / addr_w(op)) - 6'd1) begin
            next_cnt = 6'd0;
            if (op == OP_PP) begin
              next_pg_idx    = nxt_a[7:0];
              next_prot_page = nxt_a[23:8];
              clr_mask       = 1'b1;
              next_phase     = ST_XFER;
            end else begin
              next_rd_addr = nxt_a;
              next_phase   = (dummy_clks(op) != 4'd0) ? ST_DUMMY : ST_XFER;
            end
          end
        end
        ST_DUMMY: begin
          // Lane values here are don't-care, continuation bits included
          next_cnt = cnt + 6'd1;
          if (cnt == 6'(dummy_clks(op)) - 6'd1) begin
            next_cnt   = 6'd0;
            next_phase = ST_XFER;
          end
        end
        ST_XFER: begin
          if (in_op) begin
            next_sh   = sh_in[7:0];
            next_bcnt = bcnt + 3'd1;
            if (bcnt == last) begin
              next_bcnt = 3'd0;
              if (got != 2'd2)
                next_got = got + 2'd1;
              if (op == OP_PP) begin
                buf_we      = 1'b1;
                next_pg_idx = pg_idx + 8'd1;
              end
              if (op == OP_WRSR && got == 2'd0)
                next_st1 = next_sh;
              if (op == OP_WRSR && got == 2'd1)
                next_st2 = next_sh;
              if (op == OP_WRAP && got == 2'd0)
                next_wrap = next_sh[6:4];
            end
          end
        end
        ST_DROP: next_phase = ST_DROP;
        default: next_phase = ST_DROP;
      endcase
    end else if (fall && phase == ST_XFER && !in_op) begin
      // Output bits change on falling edges, MSB first
      case (w)
        3'd2: begin
          next_lane_out = {2'b00, byte_v[7:6]};
          next_lane_oe  = 4'h3;
        end
        3'd4: begin
          next_lane_out = byte_v[7:4];
          next_lane_oe  = 4'hf;
        end
        default: begin
          next_lane_out = {2'b00, byte_v[7], 1'b0};
          next_lane_oe  = 4'h2;
        end
      endcase
      next_sh   = byte_v << w;
      next_bcnt = (bcnt == last) ? 3'd0 : bcnt + 3'd1;
      if (bcnt == 3'd0 && op != OP_RDSR)
        next_rd_addr = next_rd(rd_addr, op, wrap_cfg);
    end
  end

  // Engine registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase            <= ST_OPC;
      op               <= 8'h00;
      cnt              <= 6'd0;
      bcnt             <= 3'd0;
      got              <= 2'd0;
      addr             <= 24'h000000;
      sh               <= 8'h00;
      st1              <= 8'h00;
      st2              <= 8'h00;
      rd_addr          <= 24'h000000;
      lane_out         <= 4'h0;
      lane_oe          <= 4'h0;
      write_latch_flag <= 1'b0;
      sr1h             <= 6'h00;
      sr2              <= 8'h00;
      wrap_cfg         <= WRAP_RST;
      pg_idx           <= 8'h00;
      prot_page        <= 16'h0000;
      busy             <= 1'b0;
      prog             <= 1'b0;
      bcyc             <= 20'h00000;
      wr_en            <= 1'b0;
      wr_addr          <= 24'h000000;
      wr_data          <= 8'h00;
    end else if (ce) begin
      phase            <= next_phase;
      op               <= next_op;
      cnt              <= next_cnt;
      bcnt             <= next_bcnt;
      got              <= next_got;
      addr             <= next_addr;
      sh               <= next_sh;
      st1              <= next_st1;
      st2              <= next_st2;
      rd_addr          <= next_rd_addr;
      lane_out         <= next_lane_out;
      lane_oe          <= next_lane_oe;
      write_latch_flag <= next_wel;
      sr1h             <= next_sr1h;
      sr2              <= next_sr2;
      wrap_cfg         <= next_wrap;
      pg_idx           <= next_pg_idx;
      prot_page        <= next_prot_page;
      busy             <= next_busy;
      prog             <= next_prog;
      bcyc             <= next_bcyc;
      wr_en            <= next_wr_en;
      wr_addr          <= next_wr_addr;
      wr_data          <= next_wr_data;
    end
  end

  // Page buffer; later bytes overwrite earlier ones at the same index
  always_ff @(posedge sys_clk) begin
    if (ce && buf_we)
      pg_buf[pg_idx] <= next_sh;
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (rst || (ce && clr_mask))
        pg_mask[i] <= 1'b0;
      else if (ce && buf_we && pg_idx == 8'(i))
        pg_mask[i] <= 1'b1;
    end
  end

endmodule : flash_cmd_decoder
`default_nettype wire

// [flash_cmd_pkg.sv]
// Purpose: constants and types for the serial flash read/program decoder
// Assumes: one 20 MHz system clock; SPI pins sampled through synchronisers
// Notes: protection decode and the memory array live outside the decoder
package flash_cmd_pkg;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP   = 8'h02;
  localparam logic [7:0] OP_RD   = 8'h03;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_FRD  = 8'h0b;
  localparam logic [7:0] OP_DOR  = 8'h3b;
  localparam logic [7:0] OP_QOR  = 8'h6b;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_DIO  = 8'hbb;
  localparam logic [7:0] OP_QIO  = 8'heb;
  localparam int CLK_NS      = 50;
  localparam int T_PROG_NS   = 700000;  // Plain default
  localparam int T_STAT_NS   = 500000;  // Plain default
  localparam int PROG_CNT    = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int STAT_CNT    = (T_STAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_BITS   = 24;
  localparam int PAGE_BYTES  = 256;
  localparam int FAST_DUMMY  = 8;
  localparam int DIO_MODE    = 4;       // Continuation bits over two lanes
  localparam int QIO_DUMMY   = 6;       // Two mode clocks plus four dummies
  localparam int QUAD_EN_BIT = 1;
  localparam int SR1_KEEP_LO = 2;       // Busy and latch bits are read-only
  localparam logic [2:0] WRAP_RST = 3'h4;
  typedef enum logic [2:0] {
    ST_OPC   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DUMMY = 3'b011,
    ST_XFER  = 3'b010,
    ST_DROP  = 3'b110
  } phase_t;
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] lane;  // lane[0] is serial_in_lane / lane_zero
  } spi_pins_t;
  typedef struct packed {
    logic [1:0] len;   // wrap_length_field
    logic       dis;   // wrap_disable_bit
  } wrap_cfg_t;
  localparam spi_pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, lane: 4'h0};
endpackage : flash_cmd_pkg

// [flash_cmd_decoder_chk.sv]
// Purpose: port checks for the flash command decoder
// Assumes: single sys_clk domain, synchronous rst
// Notes: bound into every decoder instance
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_decoder_chk
  import flash_cmd_pkg::*;
(
  input wire logic        sys_clk,          // Clock
  input wire logic        rst,              // Reset
  input wire spi_pins_t   pins,             // Pins
  input wire logic [3:0]  lane_oe,          // Lane enables
  input wire logic        wr_en,            // Write strobe
  input wire logic [23:0] wr_addr,          // Write address
  input wire logic [15:0] prot_page,        // Program page
  input wire logic        busy,             // Busy
  input wire logic        write_latch_flag, // Latch
  input wire logic        quad_lane_enable, // Quad enable
  input wire wrap_cfg_t   wrap_cfg          // Wrap setting
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Reset value and self-timed cycle relations
  property p_wrap_rst; $fell(rst) |-> wrap_cfg == 3'h4; endproperty
  a_wrap_rst: assert property (p_wrap_rst) else $error("wrap not reset");
  property p_wr_busy; wr_en |-> busy; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write outside cycle");
  property p_wr_page; wr_en |-> wr_addr[23:8] == prot_page; endproperty
  a_wr_page: assert property (p_wr_page) else $error("write left page");
  property p_busy_end; $fell(busy) |-> !write_latch_flag; endproperty
  a_busy_end: assert property (p_busy_end) else $error("latch kept");
  property p_latch_first; $rose(busy) |-> write_latch_flag; endproperty
  a_latch_first: assert property (p_latch_first) else $error("cycle without latch");
  property p_busy_min; $rose(busy) |-> busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  // Lane drive limits; sync latency is under eight cycles
  property p_oe_idle; pins.cs_n [*8] |-> lane_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven when idle");
  property p_quad_gate; !quad_lane_enable |-> lane_oe[3:2] == 2'h0; endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad lanes driven");
endmodule : flash_cmd_decoder_chk
bind flash_cmd_decoder flash_cmd_decoder_chk chk_i (.sys_clk, .rst, .pins, .lane_oe, .wr_en,
  .wr_addr, .prot_page, .busy, .write_latch_flag, .quad_lane_enable, .wrap_cfg);
`default_nettype wire

// [spi_host_model.sv]
// Purpose: mode 0 SPI host model for the decoder pins
// Assumes: sclk half period of eight sys_clk cycles
// Notes: sclk stands low outside frames
`timescale 1ns/1ns
`default_nettype none
module spi_host_model
  import flash_cmd_pkg::*;
(
  input wire logic [3:0] lane_out, // Device lane values
  input wire logic [3:0] lane_oe,  // Device lane enables
  input wire logic       sys_clk,  // Clock
  output var spi_pins_t  pins      // Wire levels
);
  logic       cs_n = 1'b1;
  logic       sclk = 1'b0;
  logic       drv  = 1'b0;
  logic       tgl  = 1'b0;
  logic [3:0] val  = 4'h0;
  // Released lanes flip each cycle so stale bits never read back
  always @(posedge sys_clk) tgl <= ~tgl;
  // Wire level from both drivers
  always_comb begin
    pins.cs_n = cs_n;
    pins.sclk = sclk;
    for (int i = 0; i < 4; i++) pins.lane[i] = lane_oe[i] ? lane_out[i] : (drv ? val[i] : tgl);
  end
  // Frame edges
  task automatic start();
    @(negedge sys_clk) cs_n = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : start
  task automatic stop();
    @(negedge sys_clk) cs_n = 1'b1;
    drv = 1'b0;
    repeat (12) @(negedge sys_clk);
  endtask : stop
  // One sclk period; lanes sampled at the rise
  task automatic clk(input logic [3:0] v, input logic d, output logic [3:0] got);
    @(negedge sys_clk) val = v;
    drv = d;
    repeat (7) @(negedge sys_clk);
    sclk = 1'b1;
    got = pins.lane;
    repeat (8) @(negedge sys_clk);
    sclk = 1'b0;
  endtask : clk
endmodule : spi_host_model
`default_nettype wire

// [test_serial_flash_read_program_decoder.sv]
// Purpose: self-checking bench for the flash command decoder
// Assumes: program and status cycles shortened to 1000 and 10
// Notes: array content is a fixed function of the address
`timescale 1ns/1ns
`default_nettype none
module test_serial_flash_read_program_decoder
  import flash_cmd_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        page_locked = 1'b0;
  logic        seen_oe = 1'b0;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] wq[$];
  spi_pins_t   pins;
  logic [3:0]  lane_out;
  logic [3:0]  lane_oe;
  logic [23:0] rd_addr;
  logic [23:0] wr_addr;
  logic [15:0] prot_page;
  logic [7:0]  mem_rdata;
  logic [7:0]  wr_data;
  logic [7:0]  status_one;
  logic [7:0]  status_two;
  logic        wr_en;
  logic        busy;
  logic        write_latch_flag;
  logic        quad_lane_enable;
  wrap_cfg_t   wrap_cfg;
  function automatic logic [7:0] mf(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : mf
  function automatic logic [31:0] e2(input logic [23:0] a, input logic [23:0] b);
    return {16'h0, mf(a), mf(b)};
  endfunction : e2
  // Array model answers within the same cycle
  assign mem_rdata = mf(rd_addr);
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  // Monitors of writes and lane drive; timeout guard
  always @(negedge sys_clk) if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
  always @(negedge sys_clk) if (lane_oe !== 4'h0) seen_oe <= 1'b1;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      stop_test();
    end
  end
  flash_cmd_decoder #(.PROG_CYCLES(1000), .STAT_CYCLES(10)) DUT (
    .sys_clk, .rst, .ce, .pins, .lane_out, .lane_oe, .rd_addr, .mem_rdata, .wr_en,
    .wr_addr, .wr_data, .prot_page, .page_locked, .busy, .write_latch_flag,
    .quad_lane_enable, .status_one, .status_two, .wrap_cfg);
  spi_host_model host (.lane_out, .lane_oe, .sys_clk, .pins);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Shift n clocks of w lanes, high lane carries the high bit
  task automatic tx(input logic [31:0] v, input int n, input int w);
    logic [3:0] g;
    for (int i = n - 1; i >= 0; i--) host.clk(4'((v >> (i * w)) & ((32'h1 << w) - 1)), 1'b1, g);
  endtask : tx
  task automatic rx(input int n, input int w, output logic [31:0] v);
    logic [3:0] g;
    v = '0;
    for (int i = 0; i < n; i++) begin
      host.clk(4'h0, 1'b0, g);
      v = (v << w) | 32'(w == 1 ? {3'h0, g[1]} : (w == 2 ? {2'h0, g[1:0]} : g));
    end
  endtask : rx
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int aw, input int nd,
                    input int dw, input int nb, output logic [31:0] v);
    logic [3:0] g;
    host.start();
    tx({24'h0, op}, 8, 1);
    tx({8'h0, a}, 24 / aw, aw);
    // Lanes let go in the last dummy clock, before its falling edge
    if (nd > 0) begin
      tx('1, nd - 1, aw);
      host.clk(4'hf, 1'b0, g);
    end
    rx(nb * 8 / dw, dw, v);
    host.stop();
  endtask : rd
  task automatic wren();
    host.start();
    tx(32'h06, 8, 1);
    host.stop();
  endtask : wren
  task automatic wait_idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge sys_clk);
    chk("idle", busy, 1'b0);
  endtask : wait_idle
  task automatic wsr(input logic [15:0] d, input int n);
    wren();
    host.start();
    tx(32'h01, 8, 1);
    tx({16'h0, d}, n, 1);
    host.stop();
    wait_idle();
  endtask : wsr
  task automatic set_wrap(input logic [7:0] b);
    host.start();
    tx(32'h77, 8, 1);
    tx(32'h0, 6, 4);
    tx({24'h0, b}, 2, 4);
    host.stop();
  endtask : set_wrap
  task automatic t_reset();
    chk("wrap_rst", wrap_cfg, 3'h4);
    chk("oe_rst", lane_oe, 4'h0);
  endtask : t_reset
  task automatic t_reads();
    logic [31:0] v;
    rd(8'h03, 24'h0012fe, 1, 0, 1, 3, v);
    chk("read", v, {8'h0, mf(24'h0012fe), mf(24'h0012ff), mf(24'h001300)});
    rd(8'h0b, 24'h00a0b1, 1, 8, 1, 2, v);
    chk("fast", v, e2(24'h00a0b1, 24'h00a0b2));
    rd(8'h3b, 24'h01f0ff, 1, 8, 2, 2, v);
    chk("dual", v, e2(24'h01f0ff, 24'h01f100));
    rd(8'hbb, 24'h05c0de, 2, 4, 2, 2, v);
    chk("dual_io", v, e2(24'h05c0de, 24'h05c0df));
  endtask : t_reads
  task automatic t_quad_off();
    logic [31:0] v;
    seen_oe = 1'b0;
    rd(8'h6b, 24'h000010, 1, 8, 4, 1, v);
    rd(8'heb, 24'h000010, 4, 6, 4, 1, v);
    chk("quad_off", seen_oe, 1'b0);
  endtask : t_quad_off
  task automatic t_status();
    wsr(16'h0002, 16);
    chk("st2", status_two, 8'h02);
    chk("qe", quad_lane_enable, 1'b1);
    chk("wel_st", write_latch_flag, 1'b0);
    wsr(16'h001c, 8);
    chk("st1", status_one, 8'h1c);
    chk("st2_kept", status_two, 8'h02);
  endtask : t_status
  task automatic t_quad();
    logic [31:0] v;
    rd(8'h6b, 24'h00c3f0, 1, 8, 4, 2, v);
    chk("quad", v, e2(24'h00c3f0, 24'h00c3f1));
    rd(8'heb, 24'h7e5a0f, 4, 6, 4, 2, v);
    chk("quad_io", v, e2(24'h7e5a0f, 24'h7e5a10));
  endtask : t_quad
  task automatic t_wrap();
    logic [31:0] v;
    logic [23:0] a;
    // Every length; bit 7 and low nibble set to prove they are ignored
    for (int l = 0; l < 4; l++) begin
      a = 24'h003100 + 24'(8 << l) - 24'h1;
      set_wrap({1'b1, 2'(l), 1'b0, 4'ha});
      chk("wrap", wrap_cfg, {2'(l), 1'b0});
      rd(8'heb, a, 4, 6, 4, 2, v);
      chk("wrapped", v, e2(a, 24'h003100));
    end
    set_wrap(8'h10);
    chk("wrap_off", wrap_cfg, 3'h1);
    rd(8'heb, 24'h003107, 4, 6, 4, 2, v);
    chk("linear", v, e2(24'h003107, 24'h003108));
    // Reset in mid-run must restore the reset wrap setting, 32-byte wrap enabled
    set_wrap(8'h60);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk("wrap_rst2", wrap_cfg, 3'h4);
  endtask : t_wrap
  task automatic t_prog();
    logic [31:0] v;
    wq.delete();
    wren();
    chk("wel", write_latch_flag, 1'b1);
    host.start();
    tx(32'h02, 8, 1);
    tx(32'h0042fe, 24, 1);
    tx(32'ha1b2c3, 24, 1);
    host.stop();
    chk("busy", busy, 1'b1);
    // Clock enable low must hold the cycle timer where it stands
    ce = 1'b0;
    repeat (1100) @(negedge sys_clk);
    chk("frozen", busy, 1'b1);
    ce = 1'b1;
    host.start();
    tx(32'h05, 8, 1);
    rx(8, 1, v);
    host.stop();
    chk("status_busy", v, 32'h03);
    seen_oe = 1'b0;
    rd(8'h03, 24'h0042fe, 1, 0, 1, 1, v);
    chk("ignored", seen_oe, 1'b0);
    wait_idle();
    chk("count", wq.size(), 3);
    chk("w0", wq[0], 32'h004200c3);
    chk("w1", wq[1], 32'h0042fea1);
    chk("w2", wq[2], 32'h0042ffb2);
    chk("wel_end", write_latch_flag, 1'b0);
  endtask : t_prog
  task automatic pp(input logic [31:0] d, input int n);
    host.start();
    tx(32'h02, 8, 1);
    tx(32'h004410, 24, 1);
    tx(d, n, 1);
    host.stop();
  endtask : pp
  task automatic t_prog_bad();
    wq.delete();
    wren();
    pp(32'h5a5, 11);
    chk("partial", busy, 1'b0);
    page_locked = 1'b1;
    wren();
    pp(32'h5a, 8);
    chk("locked", busy, 1'b0);
    page_locked = 1'b0;
    // Latch cleared by write disable; program must then be refused
    host.start();
    tx(32'h04, 8, 1);
    host.stop();
    chk("wrdi", write_latch_flag, 1'b0);
    pp(32'h5a, 8);
    chk("no_latch", busy, 1'b0);
    chk("no_writes", wq.size(), 0);
  endtask : t_prog_bad
  // Main sequence after five reset cycles
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_reads();
    t_quad_off();
    t_status();
    t_quad();
    t_wrap();
    t_prog();
    t_prog_bad();
    stop_test();
  end
endmodule : test_serial_flash_read_program_decoder
`default_nettype wire
